//--- rsa_pkg.sv
// Behaviour
// R1: Hardware pin sets voltage below 3 V, else 54 V.
// R2: First firmware voltage command ends pin control until a power recycle.
// R3: Open mode pin two-wire; 1k-5k to return multidrop.
// R4: Answer address 100 plus four position bits.
// R5: Address bit 0: zero writes, one reads.
// R6: Also accept writes at broadcast address 00.
// R7: Broadcast read flags an invalid command.
// R8: Host confirms broadcast by reading each unit.
// R9: Broadcast may switch output or change voltage.
// R10: Unit level quantized to ten; 3.3 V invalid.
// R11: Rack level quantized to eight positions.
// R12: Racks 1-4, units 1-4: rack and unit fields.
// R13: Racks 6-8, units 1-5 count upward; rack 5 none.
// R14: Units 6-10 use the second mapping table.
// R15: Output power only with slot interlock satisfied.
// R16: Multidrop address is bay, slot and shelf.
// R17: Slot level quantized to ten; 3.3 V invalid.
// R18: Shelf level accepted within its tabulated window.
// R19: Nearest-level thresholds; outside table means no position.
// R20: Power recycle restores pin control of voltage.
package rsa_pkg;

    // Levels are millivolts from the on-chip converter.
    localparam int LW = 16;

    // Unit and slot windows, midway between nominal levels.
    localparam logic [15:0] TEN_LO [10] = '{16'h0B13, 16'h09C9, 16'h087F, 16'h0735, 16'h05EB,
                                           16'h04A1, 16'h0357, 16'h020D, 16'h00B4, 16'h0000};
    localparam logic [15:0] TEN_HI [10] = '{16'h0C4D, 16'h0B12, 16'h09C8, 16'h087E, 16'h0734,
                                           16'h05EA, 16'h04A0, 16'h0356, 16'h020C, 16'h00B3};
    // Rack windows; the top position is the open pull-up level.
    localparam logic [15:0] RACK_LO [8] = '{16'h0BEA, 16'h09F6, 16'h0802, 16'h0640,
                                           16'h04B0, 16'h02EE, 16'h00FA, 16'h0000};
    localparam logic [15:0] RACK_HI [8] = '{16'hFFFF, 16'h0BE9, 16'h09F5, 16'h0801,
                                           16'h063F, 16'h04AF, 16'h02ED, 16'h00F9};
    // Shelf windows, minimum to maximum.
    localparam logic [15:0] SHELF_LO [10] = '{16'h08FC, 16'h125C, 16'h1CE8, 16'h251C, 16'h2E18,
                                             16'h3778, 16'h40D8, 16'h4A38, 16'h5334, 16'h5CF8};
    localparam logic [15:0] SHELF_HI [10] = '{16'h0A8C, 16'h14B4, 16'h1DB0, 16'h2904, 16'h3390,
                                             16'h3DB8, 16'h47E0, 16'h5208, 16'h5C30, 16'h66BC};

    // Voltage programming constants.
    localparam logic [15:0] VPROG_LIMIT_MV  = 16'h0BB8;
    localparam logic [15:0] VOUT_DEFAULT_MV = 16'hD2F0;
    localparam logic [15:0] VOUT_BASE_MV    = 16'hABE0;
    localparam logic [12:0] VPROG_GAIN      = 13'h12AB;
    localparam int          VPROG_SHIFT     = 10;

    // Mode strap resistance window in ohms.
    localparam logic [15:0] MODE_RES_MIN = 16'h03E8;
    localparam logic [15:0] MODE_RES_MAX = 16'h1388;

    // Address byte layout and commands.
    localparam logic [2:0] ADDR_PREFIX  = 3'h4;
    localparam logic [6:0] ADDR_BCAST   = 7'h00;
    localparam logic [7:0] CMD_VOUT     = 8'h21;
    localparam logic [7:0] CMD_OPER     = 8'h01;
    localparam int         OPER_ON_BIT  = 7;
    localparam logic [3:0] SLOT_SHORTED = 4'hA;

    // Bus engine states.
    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_ADDR = 6'h02,
        ST_AACK = 6'h04,
        ST_DATA = 6'h08,
        ST_DACK = 6'h10,
        ST_SKIP = 6'h20
    } rsa_state_t;

endpackage : rsa_pkg

//--- rsa_sync2.sv
// Two-flop synchroniser for pins from outside the core clock domain.
module rsa_sync2 #(
    parameter int W = 1
) (
    input  wire logic         core_clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta_q; // First stage, read only by the second stage.

    // Pins idle high on an open-drain bus, so reset to ones.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            meta_q   <= '1;
            sync_out <= '1;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule : rsa_sync2

//--- rsa_level_quant.sv
// Window quantizer: finds the table entry whose window holds the level.
module rsa_level_quant #(
    parameter int          N       = 10,
    parameter logic [15:0] LO [N]  = '{default: 16'h0000},
    parameter logic [15:0] HI [N]  = '{default: 16'h0000}
) (
    input  wire logic [15:0] level_mv,
    output logic      [3:0]  position,
    output logic             valid
);
    logic [N-1:0] hit; // One bit per window that holds the level.

    // Each entry compares its own window.
    for (genvar i = 0; i < N; i++) begin : g_win
        assign hit[i] = (level_mv >= LO[i]) && (level_mv <= HI[i]); // [R19]
    end

    // Windows do not overlap, so the lowest hit is the only hit.
    always_comb begin
        position = 4'h0;
        valid    = 1'b0;
        for (int i = N - 1; i >= 0; i--) begin
            if (hit[i]) begin
                position = 4'(i + 1);
                valid    = 1'b1;
            end
        end
    end
endmodule : rsa_level_quant

//--- rsa_top.sv
// Address derivation, control arbitration and address-byte front end.
module rsa_top (
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic [15:0] mode_res_ohms,
    input  wire logic [15:0] unit_position_level,
    input  wire logic [15:0] rack_position_level,
    input  wire logic [15:0] slot_position_level,
    input  wire logic [15:0] shelf_position_level,
    input  wire logic [15:0] voltage_program_pin,
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe_n,
    input  wire logic        invalid_cmd_clr,
    output logic             invalid_cmd,
    output logic             multidrop_mode,
    output logic [3:0]       position_address_bits,
    output logic             position_valid,
    output logic [3:0]       bay_position,
    output logic [3:0]       slot_position,
    output logic [3:0]       shelf_position,
    output logic             multidrop_addr_valid,
    output logic             hw_control,
    output logic [15:0]      vout_setpoint_mv,
    output logic             main_output_en
);
    import rsa_pkg::*;

    // Quantized positions from the sensed levels.
    logic [3:0] unit_pos, rack_pos, slot_pos, shelf_pos;
    logic       unit_ok, rack_ok, slot_ok, shelf_ok;

    rsa_level_quant #(.N(10), .LO(TEN_LO), .HI(TEN_HI)) u_unit ( // [R10]
        .level_mv (unit_position_level),
        .position (unit_pos),
        .valid    (unit_ok)
    );
    rsa_level_quant #(.N(8), .LO(RACK_LO), .HI(RACK_HI)) u_rack ( // [R11]
        .level_mv (rack_position_level),
        .position (rack_pos),
        .valid    (rack_ok)
    );
    rsa_level_quant #(.N(10), .LO(TEN_LO), .HI(TEN_HI)) u_slot ( // [R17]
        .level_mv (slot_position_level),
        .position (slot_pos),
        .valid    (slot_ok)
    );
    rsa_level_quant #(.N(10), .LO(SHELF_LO), .HI(SHELF_HI)) u_shelf ( // [R18]
        .level_mv (shelf_position_level),
        .position (shelf_pos),
        .valid    (shelf_ok)
    );

    // Map unit and rack positions onto the four address bits.
    function automatic logic [4:0] pos_code(input logic [3:0] u, input logic [3:0] r);
        logic [4:0] c;
        c = 5'h00;
        if (u >= 4'h1 && u <= 4'h4 && r >= 4'h1 && r <= 4'h4) begin
            c = {1'b1, 2'(r - 4'h1), 2'(u - 4'h1)}; // [R12]
        end else if (u >= 4'h1 && u <= 4'h5 && r >= 4'h6) begin
            c = {1'b1, 4'((r - 4'h6) * 4'h5 + (u - 4'h1))}; // [R13]
        end else if (u == 4'h6 || u == 4'h7) begin
            c = {1'b1, 4'((r - 4'h1) * 4'h2 + (u - 4'h6))}; // [R14]
        end else if (u >= 4'h8 && r >= 4'h4) begin
            c = {1'b1, 4'((r - 4'h4) * 4'h3 + (u - 4'h8))}; // [R14]
        end
        return c;
    endfunction : pos_code

    logic [4:0] code_w; // Valid flag above the four address bits.
    assign code_w = (unit_ok && rack_ok) ? pos_code(unit_pos, rack_pos) : 5'h00; // [R19]

    // Bus pins cross from the host's clock into the core domain.
    logic scl_s, sda_s;
    rsa_sync2 #(.W(2)) u_sync (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .async_in ({scl_in, sda_in}),
        .sync_out ({scl_s, sda_s})
    );

    // Bus engine state.
    rsa_state_t st_q, st_d;
    logic       scl_p_q, scl_p_d, sda_p_q, sda_p_d;
    logic [2:0] bit_q, bit_d;
    logic [7:0] sh_q, sh_d;
    logic [1:0] nbyte_q, nbyte_d;
    logic [7:0] cmd_q, cmd_d, d0_q, d0_d, d1_q, d1_d;
    logic       wr_q, wr_d;
    logic       drv_q, drv_d;
    logic       exec_q, exec_d;
    logic       bad_read;

    // Control state.
    logic        mode_q, mode_d, strap_q, strap_d;
    logic        fw_q, fw_d, on_q, on_d, inv_q, inv_d;
    logic [15:0] fwv_q, fwv_d, vset_q, vset_d;
    logic        en_q, en_d;
    logic [3:0]  pab_q, pab_d;
    logic        pv_q, pv_d;

    logic scl_rise, scl_fall, start_c, stop_c;
    logic [7:0] byte_in;
    logic       match_unit, match_bcast;

    // Edges are taken from the second flop and its delayed copy only.
    assign scl_rise = scl_s && !scl_p_q;
    assign scl_fall = !scl_s && scl_p_q;
    assign start_c  = scl_s && scl_p_q && !sda_s && sda_p_q;
    assign stop_c   = scl_s && scl_p_q && sda_s && !sda_p_q;
    assign byte_in  = {sh_q[6:0], sda_s};

    // A broadcast byte acknowledges only as a write; its read is refused.
    assign match_unit  = !mode_q && pv_q && byte_in[7:5] == ADDR_PREFIX
                         && byte_in[4:1] == pab_q; // [R4]
    assign match_bcast = !mode_q && byte_in[7:1] == ADDR_BCAST; // [R6]
    assign bad_read    = (st_q == ST_ADDR) && scl_rise && bit_q == 3'h7
                         && match_bcast && byte_in[0]; // [R7]

    // Next-state logic of the bus engine.
    always_comb begin
        st_d    = st_q;
        scl_p_d = scl_s;
        sda_p_d = sda_s;
        bit_d   = bit_q;
        sh_d    = sh_q;
        nbyte_d = nbyte_q;
        cmd_d   = cmd_q;
        d0_d    = d0_q;
        d1_d    = d1_q;
        wr_d    = wr_q;
        drv_d   = drv_q;
        exec_d  = 1'b0;
        if (start_c) begin
            // A start, repeated or not, always opens a new address byte.
            st_d    = ST_ADDR;
            bit_d   = 3'h0;
            nbyte_d = 2'h0;
            drv_d   = 1'b0;
        end else if (stop_c) begin
            // A stop closes a write; collected bytes then take effect.
            exec_d = (st_q == ST_DATA) && wr_q;
            st_d   = ST_IDLE;
            drv_d  = 1'b0;
        end else begin
            case (st_q)
                ST_ADDR: begin
                    if (scl_rise) begin
                        sh_d  = byte_in;
                        bit_d = 3'(bit_q + 3'h1);
                        if (bit_q == 3'h7) begin
                            wr_d = !byte_in[0]; // [R5]
                            if (match_unit || (match_bcast && !byte_in[0])) begin
                                st_d = ST_AACK;
                            end else begin
                                st_d = ST_SKIP;
                            end
                        end
                    end
                end
                ST_AACK, ST_DACK: begin
                    // Pull data low from the eighth falling edge to the ninth.
                    if (scl_fall) begin
                        drv_d = !drv_q;
                        if (drv_q) begin
                            st_d  = wr_q ? ST_DATA : ST_SKIP;
                            bit_d = 3'h0;
                        end
                    end
                end
                ST_DATA: begin
                    if (scl_rise) begin
                        sh_d  = byte_in;
                        bit_d = 3'(bit_q + 3'h1);
                        if (bit_q == 3'h7) begin
                            st_d = ST_DACK;
                            if (nbyte_q == 2'h0) begin
                                cmd_d = byte_in;
                            end else if (nbyte_q == 2'h1) begin
                                d0_d = byte_in;
                            end else if (nbyte_q == 2'h2) begin
                                d1_d = byte_in;
                            end
                            if (nbyte_q != 2'h3) begin
                                nbyte_d = 2'(nbyte_q + 2'h1);
                            end
                        end
                    end
                end
                ST_SKIP: begin
                    // Reads and foreign addresses are left alone until a stop or a new start.
                    drv_d = 1'b0;
                end
                default: begin
                    st_d = ST_IDLE;
                end
            endcase
        end
    end

    // Bus engine registers.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            st_q    <= ST_IDLE;
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
            bit_q   <= 3'h0;
            sh_q    <= 8'h00;
            nbyte_q <= 2'h0;
            cmd_q   <= 8'h00;
            d0_q    <= 8'h00;
            d1_q    <= 8'h00;
            wr_q    <= 1'b0;
            drv_q   <= 1'b0;
            exec_q  <= 1'b0;
        end else begin
            st_q    <= st_d;
            scl_p_q <= scl_p_d;
            sda_p_q <= sda_p_d;
            bit_q   <= bit_d;
            sh_q    <= sh_d;
            nbyte_q <= nbyte_d;
            cmd_q   <= cmd_d;
            d0_q    <= d0_d;
            d1_q    <= d1_d;
            wr_q    <= wr_d;
            drv_q   <= drv_d;
            exec_q  <= exec_d;
        end
    end

    logic [28:0] vprog_scaled; // Pin millivolts times the gain.
    assign vprog_scaled = voltage_program_pin * VPROG_GAIN;

    // Next-state logic of the control state.
    always_comb begin
        mode_d  = mode_q;
        strap_d = 1'b1;
        fw_d    = fw_q;
        fwv_d   = fwv_q;
        on_d    = on_q;
        pab_d   = code_w[3:0];
        pv_d    = code_w[4];
        // The strap is caught once, on the first edge after reset release.
        if (!strap_q) begin
            mode_d = mode_res_ohms >= MODE_RES_MIN && mode_res_ohms <= MODE_RES_MAX; // [R3]
        end
        // Set wins over a clear arriving in the same cycle.
        inv_d = (inv_q && !invalid_cmd_clr) || bad_read; // [R7]
        // Broadcast and own-address writes act alike, so all units move together.
        if (exec_q) begin
            if (cmd_q == CMD_VOUT && nbyte_q >= 2'h3) begin
                fw_d  = 1'b1; // [R2]
                fwv_d = {d1_q, d0_q}; // [R9]
            end else if (cmd_q == CMD_OPER && nbyte_q >= 2'h2) begin
                on_d = d0_q[OPER_ON_BIT]; // [R9]
            end
        end
        // The pin is obeyed only until the first firmware voltage command.
        if (fw_q) begin
            vset_d = fwv_q; // [R2]
        end else if (voltage_program_pin < VPROG_LIMIT_MV) begin
            vset_d = 16'(VOUT_BASE_MV + 16'(vprog_scaled >> VPROG_SHIFT)); // [R1]
        end else begin
            vset_d = VOUT_DEFAULT_MV; // [R1]
        end
        // Two-wire needs a shorted slot; multidrop accepts any valid slot.
        en_d = on_q && (mode_q ? slot_ok : (slot_ok && slot_pos == SLOT_SHORTED)); // [R15]
    end

    // Control registers; reset stands for a bias power recycle.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            mode_q <= 1'b0;
            strap_q <= 1'b0;
            fw_q   <= 1'b0; // [R20]
            fwv_q  <= VOUT_DEFAULT_MV;
            on_q   <= 1'b1;
            inv_q  <= 1'b0;
            vset_q <= VOUT_DEFAULT_MV;
            en_q   <= 1'b0;
            pab_q  <= 4'h0;
            pv_q   <= 1'b0;
        end else begin
            mode_q <= mode_d;
            strap_q <= strap_d;
            fw_q   <= fw_d;
            fwv_q  <= fwv_d;
            on_q   <= on_d;
            inv_q  <= inv_d;
            vset_q <= vset_d;
            en_q   <= en_d;
            pab_q  <= pab_d;
            pv_q   <= pv_d;
        end
    end

    // Outputs; multidrop parts are plain positions, bay from the unit level.
    assign sda_out               = 1'b0;
    assign sda_oe_n              = !drv_q;
    assign invalid_cmd           = inv_q;
    assign multidrop_mode        = mode_q;
    assign position_address_bits = pab_q;
    assign position_valid        = pv_q;
    assign bay_position          = unit_pos; // [R16]
    assign slot_position         = slot_pos;
    assign shelf_position        = shelf_pos;
    assign multidrop_addr_valid  = mode_q && unit_ok && slot_ok && shelf_ok; // [R16]
    assign hw_control            = !fw_q;
    assign vout_setpoint_mv      = vset_q;
    assign main_output_en        = en_q;
endmodule : rsa_top

//--- rsa_host_model.sv
// Bus master standing in for the system host.
module rsa_host_model (
    output logic scl,
    output logic sda_drv,
    input  logic sda_wire
);
    timeunit 1ns;
    timeprecision 1ps;

    // Both lines rest high; the clock stands still between frames.
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end

    // Start: data falls, clock high.
    task automatic frame_start();
        sda_drv = 1'b0;
        #80 scl = 1'b0;
        #40;
    endtask : frame_start

    // Stop: data rises, clock high.
    task automatic frame_stop();
        sda_drv = 1'b0;
        #40 scl = 1'b1;
        #40 sda_drv = 1'b1;
        #80;
    endtask : frame_stop

    // Eight bits MSB first, then data is released for the acknowledge.
    // Data moves only mid-low, never while the clock is high.
    task automatic put_byte(input logic [7:0] b, output logic ack);
        for (int i = 8; i >= 0; i--) begin
            sda_drv = (i == 0) ? 1'b1 : b[i-1];
            #40 scl = 1'b1;
            #70 if (i == 0) ack = ~sda_wire;
            #10 scl = 1'b0;
            #40;
        end
    endtask : put_byte
endmodule : rsa_host_model

//--- rsa_top_asserts.sv
// Checks on the address front end and control arbitration.
module rsa_chk (
    input logic        core_clk,
    input logic        rst_n,
    input logic [15:0] voltage_program_pin,
    input logic        sda_oe_n,
    input logic        invalid_cmd_clr,
    input logic        invalid_cmd,
    input logic        multidrop_mode,
    input logic        position_valid,
    input logic [3:0]  bay_position,
    input logic [3:0]  slot_position,
    input logic [3:0]  shelf_position,
    input logic        multidrop_addr_valid,
    input logic        hw_control,
    input logic [15:0] vout_setpoint_mv,
    input logic        main_output_en
);
    // One domain; checks rest during reset.
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    a_fw_keeps: assert property (!hw_control |=> !hw_control)
        else $error("Pin control returned.");
    a_pin_dflt: assert property (
        hw_control && voltage_program_pin >= 16'h0BB8 && $stable(voltage_program_pin)
        |=> vout_setpoint_mv == 16'hD2F0)
        else $error("Default setpoint missing.");
    a_pin_scale: assert property (
        hw_control && voltage_program_pin < 16'h0BB8 && $stable(voltage_program_pin)
        |=> vout_setpoint_mv == 16'(32'hABE0 + ((32'($past(voltage_program_pin)) * 32'h12AB) >> 10)))
        else $error("Setpoint off the pin.");
    a_md_silent: assert property (multidrop_mode |-> sda_oe_n)
        else $error("Ack in multidrop mode.");
    a_bad_pos: assert property (!position_valid && $past(position_valid) == 1'b0 |-> sda_oe_n)
        else $error("Ack without position.");
    a_ack_len: assert property ($fell(sda_oe_n) |-> !sda_oe_n [*6] ##[1:4] sda_oe_n)
        else $error("Bad ack length.");
    a_bc_read: assert property ($rose(invalid_cmd) |-> sda_oe_n [*8])
        else $error("Broadcast read acked.");
    a_flag_hold: assert property (invalid_cmd && !invalid_cmd_clr |=> invalid_cmd)
        else $error("Flag dropped alone.");
    a_interlock: assert property (
        main_output_en |-> ($past(multidrop_mode) ? $past(slot_position) != 4'h0 : $past(slot_position) == 4'hA))
        else $error("Output on without interlock.");
    a_md_addr: assert property (
        multidrop_addr_valid == (multidrop_mode && bay_position != 4'h0 && slot_position != 4'h0
                                 && shelf_position != 4'h0))
        else $error("Bad multidrop valid.");
endmodule : rsa_chk

bind rsa_top rsa_chk u_chk (.*);

//--- tb.sv
// Bench for the address and control block.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        core_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [15:0] mode_res_ohms = 16'hFFFF;
    logic [15:0] unit_position_level = 16'h0BB8;
    logic [15:0] rack_position_level = 16'h0CE4;
    logic [15:0] slot_position_level = 16'h0000;
    logic [15:0] shelf_position_level = 16'h0000;
    logic [15:0] voltage_program_pin = 16'hFFFF;
    logic        invalid_cmd_clr = 1'b0;
    logic        scl_in, sda_in, h_sda, sda_out, sda_oe_n, invalid_cmd, multidrop_mode;
    logic        position_valid, multidrop_addr_valid, hw_control, main_output_en, ack;
    logic [3:0]  position_address_bits, bay_position, slot_position, shelf_position;
    logic [15:0] vout_setpoint_mv;
    int          bad_count = 0;
    int          total_checks = 0;
    int          cyc = 0;
    // Unit and rack levels in mV from position 1.
    localparam logic [15:0] UMV [10] = '{16'h0BB8, 16'h0A6E, 16'h0924, 16'h07DA, 16'h0690,
                                         16'h0546, 16'h03FC, 16'h02B2, 16'h0168, 16'h0000};
    localparam logic [15:0] RMV [8] = '{16'h0CE4, 16'h0AF0, 16'h08FC, 16'h0708,
                                        16'h0578, 16'h03E8, 16'h01F4, 16'h0000};
    // Unit, rack, code, valid.
    localparam logic [15:0] ACASE [15] = '{16'h1101, 16'h44F1, 16'h2391, 16'h1601, 16'h58E1,
        16'h4781, 16'h1500, 16'h5200, 16'h6101, 16'h78F1, 16'h8401, 16'hA8E1, 16'h9300, 16'h6581, 16'h9671};
    // Slot, shelf levels and expected positions.
    localparam logic [39:0] PCASE [5] = '{{16'h0000, 16'h09C4, 8'hA1}, {16'h0CE4, 16'h61A8, 8'h0A},
        {16'h0546, 16'h0BB8, 8'h60}, {16'h0BB8, 16'h1CE8, 8'h13}, {16'h0168, 16'h1E14, 8'h90}};
    // Strap ohms and expected mode.
    localparam logic [16:0] MCASE [4] = '{{16'h03E7, 1'b0}, {16'h03E8, 1'b1}, {16'h1389, 1'b0}, {16'h1388, 1'b1}};

    // Pulled-up wire: low when either side pulls.
    assign sda_in = h_sda & (sda_oe_n | sda_out);

    rsa_top dut (.*);
    rsa_host_model u_host (.scl(scl_in), .sda_drv(h_sda), .sda_wire(sda_in));

    // Core clock, 20 ns period.
    always #10 core_clk = ~core_clk;

    // Cycle ceiling, far above the run's length.
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            give_verdict();
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(negedge core_clk);
    endtask : tick

    // Four reset cycles; strap taken at the first edge after release.
    task automatic do_reset(input logic [15:0] strap);
        tick(1);
        rst_n = 1'b0;
        mode_res_ohms = strap;
        tick(4);
        rst_n = 1'b1;
        tick(3);
    endtask : do_reset

    // Command and two data bytes; the 7 ns offset keeps bus edges off core edges.
    task automatic wr_frame(input logic [6:0] a, input logic [7:0] c, d0, d1, input logic exp);
        logic [7:0] b [3];
        b = '{c, d0, d1};
        #7;
        u_host.frame_start();
        u_host.put_byte({a, 1'b0}, ack);
        check(ack, exp);
        foreach (b[i]) begin
            u_host.put_byte(b[i], ack);
            check(ack, exp);
        end
        u_host.frame_stop();
        tick(4);
    endtask : wr_frame

    // Read address only, stop after the acknowledge.
    task automatic rd_frame(input logic [6:0] a, input logic exp);
        #7;
        u_host.frame_start();
        u_host.put_byte({a, 1'b1}, ack);
        check(ack, exp);
        u_host.frame_stop();
        tick(4);
    endtask : rd_frame

    // Reset values, then the pin around its limit.
    task automatic t_pin();
        do_reset(16'hFFFF);
        check(hw_control, 1'b1);
        check(vout_setpoint_mv, 16'hD2F0);
        check(sda_oe_n, 1'b1);
        check(sda_out, 1'b0);
        check(invalid_cmd, 1'b0);
        check(multidrop_mode, 1'b0);
        voltage_program_pin = 16'h0BB7;
        tick(3);
        check(vout_setpoint_mv, 16'hE28C);
        voltage_program_pin = 16'h0BB8;
        tick(3);
        check(vout_setpoint_mv, 16'hD2F0);
    endtask : t_pin

    // Slot and shelf decode, two-wire interlock.
    task automatic t_pos();
        foreach (PCASE[i]) begin
            slot_position_level = PCASE[i][39:24];
            shelf_position_level = PCASE[i][23:8];
            tick(2);
            check(slot_position, PCASE[i][7:4]);
            check(shelf_position, PCASE[i][3:0]);
            check(main_output_en, PCASE[i][7:4] == 4'hA);
            check(multidrop_addr_valid, 1'b0);
        end
    endtask : t_pos

    // Unit and rack pairs through both tables, then bad units.
    task automatic t_addr();
        foreach (ACASE[i]) begin
            unit_position_level = UMV[ACASE[i][15:12] - 4'h1];
            rack_position_level = RMV[ACASE[i][11:8] - 4'h1];
            tick(2);
            check(bay_position, ACASE[i][15:12]);
            check(position_valid, ACASE[i][0]);
            if (ACASE[i][0]) check(position_address_bits, ACASE[i][7:4]);
        end
        unit_position_level = 16'h0CE4;
        tick(2);
        check(position_valid, 1'b0);
        unit_position_level = 16'h0C80;
        tick(2);
        check(bay_position, 4'h0);
    endtask : t_addr

    // Two-wire traffic and firmware takeover.
    task automatic t_bus();
        unit_position_level = 16'h0924;
        rack_position_level = 16'h0AF0;
        slot_position_level = 16'h0000;
        tick(2);
        wr_frame(7'h47, 8'h01, 8'h00, 8'h00, 1'b0);
        check(main_output_en, 1'b1);
        rd_frame(7'h46, 1'b1);
        rd_frame(7'h00, 1'b0);
        check(invalid_cmd, 1'b1);
        invalid_cmd_clr = 1'b1;
        tick(1);
        invalid_cmd_clr = 1'b0;
        tick(1);
        check(invalid_cmd, 1'b0);
        voltage_program_pin = 16'h03E8;
        tick(3);
        check(vout_setpoint_mv, 16'hBE1A);
        wr_frame(7'h00, 8'h21, 8'h50, 8'hC3, 1'b1);
        check(hw_control, 1'b0);
        check(vout_setpoint_mv, 16'hC350);
        voltage_program_pin = 16'h07D0;
        tick(3);
        check(vout_setpoint_mv, 16'hC350);
        rd_frame(7'h46, 1'b1);
        wr_frame(7'h00, 8'h01, 8'h00, 8'h00, 1'b1);
        check(main_output_en, 1'b0);
        wr_frame(7'h46, 8'h01, 8'h80, 8'h00, 1'b1);
        check(main_output_en, 1'b1);
        rack_position_level = 16'h0578;
        tick(2);
        wr_frame(7'h46, 8'h01, 8'h00, 8'h00, 1'b0);
        check(main_output_en, 1'b1);
        do_reset(16'hFFFF);
        check(hw_control, 1'b1);
        check(vout_setpoint_mv, 16'hD055);
    endtask : t_bus

    // Strap edges, then multidrop address and interlock.
    task automatic t_md();
        foreach (MCASE[i]) begin
            do_reset(MCASE[i][16:1]);
            check(multidrop_mode, MCASE[i][0]);
        end
        unit_position_level = 16'h0546;
        slot_position_level = 16'h0546;
        shelf_position_level = 16'h09C4;
        tick(2);
        check(multidrop_addr_valid, 1'b1);
        check(main_output_en, 1'b1);
        wr_frame(7'h48, 8'h01, 8'h00, 8'h00, 1'b0);
        check(main_output_en, 1'b1);
        slot_position_level = 16'h0CE4;
        tick(2);
        check(main_output_en, 1'b0);
        check(multidrop_addr_valid, 1'b0);
    endtask : t_md

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : give_verdict

    // Main sequence.
    initial begin
        t_pin();
        t_pos();
        t_addr();
        t_bus();
        t_md();
        give_verdict();
    end
endmodule : tb
